// >>> hdl/mafpb_top.sv
// Station address, group hash filter, backoff, pacing and pause timers
`timescale 1ns/1ps
module mafpb_top #(
  parameter int NCHAN = 8
) (
  // Clock, reset, enable
  input  wire logic                 clk_sys_i,
  input  wire logic                 srst_i,
  input  wire logic                 ce_i,
  // Avalon-MM slave
  input  wire mafpb_pkg::mafpb_avreq_s av_i,
  output logic [31:0]               av_readdata_o,
  output logic                      av_waitrequest_o,
  // MAC side
  input  wire logic                 test_mode_enable_i,
  input  wire logic                 speed_fast_i,
  input  wire logic [NCHAN-1:0]     chan_enable_i,
  input  wire mafpb_pkg::mafpb_ev_s ev_i,
  // Results
  output logic [NCHAN-1:0]          chan_match_en_o,
  output logic [NCHAN-1:0]          chan_hit_o,
  output logic                      hash_hit_o,
  output logic                      backoff_busy_o,
  output logic                      quad_ipg_o,
  output logic                      pause_send_req_o,
  output logic                      tx_hold_o
);

  typedef struct packed {
    logic [NCHAN-1:0][7:0] addr_lo;
    logic [7:0]            addr_mid;
    logic [31:0]           addr_hi;
    logic [NCHAN-1:0]      match_en;
    logic [63:0]           hash;
    logic [3:0]            attempt;
    logic [3:0]            retry;
    logic [10:0]           rng;
    logic [9:0]            boff;
    logic [4:0]            pace;
    logic                  quad_ipg;
    logic [15:0]           rxp;
    logic [15:0]           txp;
    logic                  pause_req;
    logic [11:0]           slot_cnt;
    logic                  hash_hit;
    logic [NCHAN-1:0]      chan_hit;
    logic [31:0]           rdata;
    mafpb_pkg::mafpb_bus_e bus;
  } mafpb_st_s;

  mafpb_st_s r;
  mafpb_st_s nxt;

  // Six-bit fold of the destination address
  function automatic logic [5:0] hash_idx(input logic [47:0] da);
    logic [5:0] h;
    h = 6'h00;
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 8; k++) begin
        h[i] = h[i] ^ da[i + 6 * k];
      end
    end
    return h;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8 * b +: 8] = wd[8 * b +: 8];
      end
    end
    return m;
  endfunction

  logic        req;
  logic        wr_acc;
  logic        rd_idle;
  logic        tick;
  logic [31:0] boff_word;
  logic [47:0] station;

  assign req       = av_i.read | av_i.write;
  assign wr_acc    = av_i.write & (r.bus == mafpb_pkg::BUS_ACK);
  assign rd_idle   = av_i.read & (r.bus == mafpb_pkg::BUS_IDLE);
  assign tick      = (r.slot_cnt == 12'h000);
  assign boff_word = {(r.boff != 10'h000), r.attempt, r.rng, r.retry,
                      2'b00, r.boff};

  always_comb begin
    logic [3:0]  att_n;
    logic [9:0]  mask;
    logic [31:0] w;
    logic [3:0]  k;
    logic [47:0] st;
    nxt   = r;
    att_n = 4'h0;
    mask  = 10'h000;
    w     = 32'h0000_0000;
    k     = 4'h0;
    st    = 48'h0;

    // Bus handshake: one wait cycle, then answer
    if (req && r.bus == mafpb_pkg::BUS_IDLE) begin
      nxt.bus = mafpb_pkg::BUS_ACK;
    end else begin
      nxt.bus = mafpb_pkg::BUS_IDLE;
    end

    // Read mux, captured while the request waits
    if (rd_idle) begin
      nxt.rdata = 32'h0000_0000;
      if (av_i.address < mafpb_pkg::OFS_ADDR_MID && av_i.address[1:0] == 2'b00) begin
        nxt.rdata = {24'h00_0000, r.addr_lo[av_i.address[4:2]]};
      end else if (av_i.address == mafpb_pkg::OFS_ADDR_MID) begin
        nxt.rdata = {24'h00_0000, r.addr_mid};
      end else if (av_i.address == mafpb_pkg::OFS_ADDR_HI) begin
        nxt.rdata = r.addr_hi;
      end else if (av_i.address == mafpb_pkg::OFS_HASH_LO) begin
        nxt.rdata = r.hash[31:0];
      end else if (av_i.address == mafpb_pkg::OFS_HASH_HI) begin
        nxt.rdata = r.hash[63:32];
      end else if (av_i.address == mafpb_pkg::OFS_BOFF) begin
        nxt.rdata = boff_word;
      end else if (av_i.address == mafpb_pkg::OFS_PACE) begin
        nxt.rdata = {27'h000_0000, r.pace};
      end else if (av_i.address == mafpb_pkg::OFS_RECEIVE_PAUSE_TIMER) begin
        nxt.rdata = {16'h0000, r.rxp};
      end else if (av_i.address == mafpb_pkg::OFS_TRANSMIT_PAUSE_TIMER) begin
        nxt.rdata = {16'h0000, r.txp};
      end
    end

    // Free-running generator, counts from the first clock after reset
    nxt.rng = r.rng + 11'h001;

    // Slot timer at 512 bit times
    if (tick) begin
      nxt.slot_cnt = speed_fast_i ? mafpb_pkg::SLOT_CYC_FAST
                                  : mafpb_pkg::SLOT_CYC_SLOW;
    end else begin
      nxt.slot_cnt = r.slot_cnt - 12'h001;
    end

    // Backoff counter decrements per slot
    if (tick && r.boff != 10'h000) begin
      nxt.boff = r.boff - 10'h001;
    end

    // Pause timers count down per slot
    nxt.pause_req = 1'b0;
    if (tick && r.rxp != 16'h0000) begin
      nxt.rxp = r.rxp - 16'h0001;
      if (r.rxp == 16'h0001) begin
        nxt.pause_req = 1'b1;
      end
    end
    if (tick && r.txp != 16'h0000) begin
      nxt.txp = r.txp - 16'h0001;
    end

    // Register writes, taken on the answering edge
    if (wr_acc) begin
      if (av_i.address < mafpb_pkg::OFS_ADDR_MID && av_i.address[1:0] == 2'b00) begin
        w = be_merge({24'h00_0000, r.addr_lo[av_i.address[4:2]]},
                     av_i.writedata, av_i.byteenable);
        nxt.addr_lo[av_i.address[4:2]]  = w[7:0];
        nxt.match_en[av_i.address[4:2]] = 1'b0;
      end else if (av_i.address == mafpb_pkg::OFS_ADDR_MID) begin
        w = be_merge({24'h00_0000, r.addr_mid}, av_i.writedata, av_i.byteenable);
        nxt.addr_mid = w[7:0];
      end else if (av_i.address == mafpb_pkg::OFS_ADDR_HI) begin
        w = be_merge(r.addr_hi, av_i.writedata, av_i.byteenable);
        nxt.addr_hi  = {w[31:1], 1'b0};
        nxt.match_en = chan_enable_i;
      end else if (av_i.address == mafpb_pkg::OFS_HASH_LO) begin
        nxt.hash[31:0] = be_merge(r.hash[31:0], av_i.writedata,
                                  av_i.byteenable);
      end else if (av_i.address == mafpb_pkg::OFS_HASH_HI) begin
        nxt.hash[63:32] = be_merge(r.hash[63:32], av_i.writedata,
                                   av_i.byteenable);
      end else if (av_i.address == mafpb_pkg::OFS_BOFF) begin
        if (test_mode_enable_i) begin
          w = be_merge(boff_word, av_i.writedata, av_i.byteenable);
          nxt.rng = w[26:16];
        end
      end else if (av_i.address == mafpb_pkg::OFS_RECEIVE_PAUSE_TIMER) begin
        if (test_mode_enable_i) begin
          w = be_merge({16'h0000, r.rxp}, av_i.writedata, av_i.byteenable);
          nxt.rxp = w[15:0];
        end
      end else if (av_i.address == mafpb_pkg::OFS_TRANSMIT_PAUSE_TIMER) begin
        if (test_mode_enable_i) begin
          w = be_merge({16'h0000, r.txp}, av_i.writedata, av_i.byteenable);
          nxt.txp = w[15:0];
        end
      end
    end

    // Collision: count attempt, load backoff from the generator
    if (ev_i.tx_collision) begin
      att_n = (r.attempt == 4'hF) ? 4'hF : r.attempt + 4'h1;
      nxt.attempt = att_n;
      k = (att_n > mafpb_pkg::BOFF_MAX_EXP) ? mafpb_pkg::BOFF_MAX_EXP : att_n;
      mask = 10'((11'h001 << k) - 11'h001);
      nxt.boff = r.rng[9:0] & mask;
    end

    // Pacing counter and stretched gap
    if (ev_i.tx_collision || ev_i.tx_defer) begin
      nxt.pace     = mafpb_pkg::PACE_LOAD;
      nxt.quad_ipg = 1'b0;
    end else if (ev_i.tx_good) begin
      nxt.quad_ipg = (r.pace != 5'h00);
      if (r.pace != 5'h00) begin
        nxt.pace = r.pace - 5'h01;
      end
      nxt.retry   = r.attempt;
      nxt.attempt = 4'h0;
    end

    // Hardware loads win over test-mode writes
    if (ev_i.pause_sent) begin
      nxt.rxp = mafpb_pkg::RECEIVE_PAUSE_TIMER_LOAD;
    end
    if (ev_i.pause_rx) begin
      nxt.txp = ev_i.pause_rx_time;
    end

    // Destination lookup
    if (ev_i.da_valid) begin
      nxt.hash_hit = r.hash[hash_idx(ev_i.da)];
      for (int c = 0; c < NCHAN; c++) begin
        st = {r.addr_hi, r.addr_mid, r.addr_lo[c]};
        nxt.chan_hit[c] = r.match_en[c] & (ev_i.da == st);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= nxt;
    end
  end

  assign station          = {r.addr_hi, r.addr_mid, r.addr_lo[0]};
  assign av_readdata_o    = r.rdata;
  assign av_waitrequest_o = req & (r.bus != mafpb_pkg::BUS_ACK);
  assign chan_match_en_o  = r.match_en;
  assign chan_hit_o       = r.chan_hit;
  assign hash_hit_o       = r.hash_hit;
  assign backoff_busy_o   = r.boff != 10'h000;
  assign quad_ipg_o       = r.quad_ipg;
  assign pause_send_req_o = r.pause_req;
  assign tx_hold_o        = r.txp != 16'h0000;

  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  sequence s_wr(logic [6:0] a);
    ce_i && wr_acc && av_i.address == a && av_i.byteenable == 4'hF;
  endsequence

  a_hi_bit_zero: assert property (station[16] == 1'b0)
    else $error("group bit of station address set");

  a_lo_write_off: assert property (s_wr(mafpb_pkg::OFS_ADDR_LO0)
      |=> !r.match_en[0] && r.addr_lo[0] == $past(av_i.writedata[7:0]))
    else $error("low byte write did not disable channel");

  a_hi_write_on: assert property (s_wr(mafpb_pkg::OFS_ADDR_HI)
      |=> r.match_en == $past(chan_enable_i))
    else $error("high write did not restore enables");

  a_resv_read_zero: assert property (ce_i && rd_idle
      && av_i.address == mafpb_pkg::OFS_ADDR_MID
      |=> !av_waitrequest_o && av_readdata_o[31:8] == 24'h00_0000)
    else $error("reserved bits not zero");

  a_hash_pick: assert property (ce_i && ev_i.da_valid
      |=> r.hash_hit == $past(r.hash[hash_idx(ev_i.da)]))
    else $error("hash lookup wrong");

  a_pace_load: assert property (ce_i && (ev_i.tx_collision || ev_i.tx_defer)
      |=> r.pace == 5'h1F && !quad_ipg_o)
    else $error("pacing not loaded");

  a_rxp_reload: assert property (ce_i && ev_i.pause_sent
      |=> r.rxp == 16'hFF00)
    else $error("receive pause timer not loaded");

  a_txp_count: assert property (ce_i && tick && r.txp != 16'h0000
      && !ev_i.pause_rx && !wr_acc
      |=> r.txp == $past(r.txp) - 16'h0001)
    else $error("transmit pause timer not counting");

  a_rng_start: assert property ($past(srst_i) && !srst_i
      |-> r.rng == 11'h000)
    else $error("generator not cleared by reset");

  a_rng_guard: assert property (s_wr(mafpb_pkg::OFS_BOFF) && !test_mode_enable_i
      |=> r.rng == $past(r.rng) + 11'h001)
    else $error("generator written outside test mode");

  a_bus_answer: assert property (req && r.bus == mafpb_pkg::BUS_IDLE && ce_i
      |-> av_waitrequest_o ##1 !av_waitrequest_o)
    else $error("bus answer not after one wait cycle");

endmodule // mafpb_top

// >>> hdl/mafpb_pkg.sv
// Package: constants and types for the address filter and pacing block
package mafpb_pkg;

  // Register byte offsets
  localparam logic [6:0] OFS_ADDR_LO0  = 7'h00;
  localparam logic [6:0] OFS_ADDR_MID  = 7'h20;
  localparam logic [6:0] OFS_ADDR_HI   = 7'h24;
  localparam logic [6:0] OFS_HASH_LO   = 7'h28;
  localparam logic [6:0] OFS_HASH_HI   = 7'h2C;
  localparam logic [6:0] OFS_BOFF      = 7'h30;
  localparam logic [6:0] OFS_PACE      = 7'h34;
  localparam logic [6:0] OFS_RECEIVE_PAUSE_TIMER   = 7'h38;
  localparam logic [6:0] OFS_TRANSMIT_PAUSE_TIMER   = 7'h3C;

  // Backoff test register field positions
  localparam int BOFF_HALT_POS  = 31;
  localparam int ATTEMPT_LSB    = 27;
  localparam int RNG_LSB        = 16;
  localparam int RETRY_LSB      = 12;

  // Load values and backoff exponent limit
  localparam logic [4:0]  PACE_LOAD     = 5'h1F;
  localparam logic [15:0] RECEIVE_PAUSE_TIMER_LOAD  = 16'hFF00;
  localparam logic [3:0]  BOFF_MAX_EXP  = 4'hA;

  // Slot time: 512 bit times at the line rate
  localparam longint SLOT_BITS   = 512;
  localparam longint CLK_HZ      = 50_000_000;
  localparam longint RATE_FAST   = 100_000_000;
  localparam longint RATE_SLOW   = 10_000_000;
  localparam logic [11:0] SLOT_CYC_FAST = 12'(SLOT_BITS * CLK_HZ / RATE_FAST - 1);
  localparam logic [11:0] SLOT_CYC_SLOW = 12'(SLOT_BITS * CLK_HZ / RATE_SLOW - 1);

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } mafpb_bus_e;

  // Avalon-MM request
  typedef struct packed {
    logic [6:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } mafpb_avreq_s;

  // Transmit and receive events from the MAC
  typedef struct packed {
    logic        tx_collision;
    logic        tx_defer;
    logic        tx_good;
    logic        pause_sent;
    logic        pause_rx;
    logic [15:0] pause_rx_time;
    logic        da_valid;
    logic [47:0] da;
  } mafpb_ev_s;

endpackage

// >>> tb/mafpb_mac_model.sv
// MAC event source standing in for the transmit and receive engines
`timescale 1ns/1ps
module mafpb_mac_model (
  // Clock and request from the block
  input  wire logic            clk_sys_i,
  input  wire logic            pause_send_req_i,
  // Event pulses to the block
  output mafpb_pkg::mafpb_ev_s ev_o
);
  mafpb_pkg::mafpb_ev_s ev_r = '0;
  logic                 resend_r = 1'b0;
  // One-cycle event; data fields turn to junk once the strobe drops
  task automatic fire(input mafpb_pkg::mafpb_ev_s e);
    mafpb_pkg::mafpb_ev_s z;
    z = '0;
    z.da = ~e.da;
    z.pause_rx_time = ~e.pause_rx_time;
    @(posedge clk_sys_i);
    ev_r <= e;
    @(posedge clk_sys_i);
    ev_r <= z;
  endtask
  // Each pause request is answered by a fresh pause frame
  always @(posedge clk_sys_i) resend_r <= pause_send_req_i;
  always_comb begin
    ev_o = ev_r;
    ev_o.pause_sent = ev_r.pause_sent | resend_r;
  end
endmodule // mafpb_mac_model

// >>> tb/mafpb_top_tb.sv
// Self-checking testbench for the address filter and pacing block
`timescale 1ns/1ps
module mafpb_top_tb;
  // Design ports
  logic                    clk_sys_i = 1'b0;
  logic                    srst_i = 1'b1;
  logic                    ce_i = 1'b1;
  mafpb_pkg::mafpb_avreq_s av_i = '0;
  logic [31:0]             av_readdata_o;
  logic                    av_waitrequest_o;
  logic                    test_mode_enable_i = 1'b0;
  logic                    speed_fast_i = 1'b1;
  logic [7:0]              chan_enable_i = 8'h81;
  mafpb_pkg::mafpb_ev_s    ev_i;
  logic [7:0]              chan_match_en_o;
  logic [7:0]              chan_hit_o;
  logic                    hash_hit_o;
  logic                    backoff_busy_o;
  logic                    quad_ipg_o;
  logic                    pause_send_req_o;
  logic                    tx_hold_o;
  // Bench state
  int                      errors = 0;
  int                      n_tests = 0;
  int                      n;
  logic [31:0]             rd;
  logic [31:0]             c1;
  logic [47:0]             da;
  // Rows: address, value written, value read back
  localparam logic [70:0] ROWS [8] = '{
    {7'h00, 32'hFFFF_FFA5, 32'h0000_00A5},
    {7'h1C, 32'h1234_5677, 32'h0000_0077},
    {7'h20, 32'hFFFF_FF3C, 32'h0000_003C},
    {7'h24, 32'hDEAD_BEEF, 32'hDEAD_BEEE},
    {7'h28, 32'h5555_AAAA, 32'h5555_AAAA},
    {7'h2C, 32'h0F0F_0F0F, 32'h0F0F_0F0F},
    {7'h34, 32'h0000_001F, 32'h0000_0000},
    {7'h40, 32'hFFFF_FFFF, 32'h0000_0000}
  };
  localparam logic [63:0] TBL = 64'h0F0F_0F0F_5555_AAAA;
  localparam logic [47:0] STN = 48'hDEAD_BEEE_3CA5;

  mafpb_top #(.NCHAN(8)) dut (
    .clk_sys_i, .srst_i, .ce_i, .av_i, .av_readdata_o, .av_waitrequest_o,
    .test_mode_enable_i, .speed_fast_i, .chan_enable_i, .ev_i, .chan_match_en_o,
    .chan_hit_o, .hash_hit_o, .backoff_busy_o, .quad_ipg_o, .pause_send_req_o, .tx_hold_o
  );
  mafpb_mac_model mdl (
    .clk_sys_i,
    .pause_send_req_i (pause_send_req_o),
    .ev_o             (ev_i)
  );

  initial forever #10 clk_sys_i = ~clk_sys_i;

  function automatic logic [5:0] hsh(input logic [47:0] d);
    hsh = '0;
    for (int i = 0; i < 48; i++) hsh[i % 6] ^= d[i];
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      errors++;
      $display("CHECK FAILED wait expected done seen timeout");
      stop_test();
    end
  endtask

  // Avalon-MM transfer held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    av_i <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hF};
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (av_waitrequest_o !== 1'b0 && k < 20);
    rd = av_readdata_o;
    av_i <= '0;
    tmo(k, 20);
    #1;
  endtask

  task automatic ev_go(input mafpb_pkg::mafpb_ev_s e);
    mdl.fire(e);
    #1;
  endtask

  task automatic tmode(input logic v);
    @(posedge clk_sys_i);
    test_mode_enable_i <= v;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, ROWS[i][70:64], ROWS[i][63:32]);
      bus(1'b0, ROWS[i][70:64], '0);
      chk("readback", rd, ROWS[i][31:0]);
    end
    $display("test registers done");
    chk("match enables", 32'(chan_match_en_o), 32'h81);
    ev_go('{da_valid: 1'b1, da: STN, default: '0});
    chk("station hit", 32'(chan_hit_o), 32'h01);
    bus(1'b1, 7'h00, 32'h0000_00A5);
    chk("low write disables", 32'(chan_match_en_o), 32'h80);
    bus(1'b1, 7'h24, 32'hDEAD_BEEE);
    chk("high write enables", 32'(chan_match_en_o), 32'h81);
    for (int k = 0; k < 8; k++) begin
      da = 48'h0100_5E00_0000 + 48'(k * 1237);
      ev_go('{da_valid: 1'b1, da: da, default: '0});
      chk("hash hit", 32'(hash_hit_o), 32'(TBL[hsh(da)]));
    end
    $display("test filter done");
    repeat (10) ev_go('{tx_collision: 1'b1, default: '0});
    chk("gap after collision", 32'(quad_ipg_o), 32'h0);
    bus(1'b0, 7'h34, '0);
    chk("pace load", rd, 32'h1F);
    bus(1'b0, 7'h30, '0);
    chk("attempts", 32'(rd[30:27]), 32'hA);
    c1 = rd;
    repeat (253) @(posedge clk_sys_i);
    bus(1'b0, 7'h30, '0);
    if (c1[9:0] > 10'h1) begin
      chk("backoff step", 32'(rd[9:0]), 32'(c1[9:0] - 10'h1));
      if (rd[9:0] > 10'h1) chk("backoff busy", 32'(backoff_busy_o), 32'h1);
    end
    ev_go('{tx_good: 1'b1, default: '0});
    chk("gap after clean frame", 32'(quad_ipg_o), 32'h1);
    bus(1'b0, 7'h34, '0);
    chk("pace step", rd, 32'h1E);
    bus(1'b0, 7'h30, '0);
    chk("attempts cleared", 32'(rd[30:27]), 32'h0);
    ev_go('{tx_defer: 1'b1, default: '0});
    chk("gap after defer", 32'(quad_ipg_o), 32'h0);
    bus(1'b0, 7'h34, '0);
    chk("pace reload", rd, 32'h1F);
    // Clock enable low: a clean frame event must leave the pacing count frozen
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    ev_go('{tx_good: 1'b1, default: '0});
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    bus(1'b0, 7'h34, '0);
    chk("pace frozen by enable", rd, 32'h1F);
    chk("gap frozen by enable", 32'(quad_ipg_o), 32'h0);
    $display("test backoff and pacing done");
    bus(1'b0, 7'h30, '0);
    c1 = rd;
    bus(1'b1, 7'h30, 32'h07FF_0000);
    bus(1'b0, 7'h30, '0);
    chk("generator guarded", 32'((rd[26:16] - c1[26:16] - 11'h1) < 11'hF), 32'h1);
    tmode(1'b1);
    bus(1'b1, 7'h30, 32'h0123_0000);
    bus(1'b0, 7'h30, '0);
    chk("generator written", 32'((rd[26:16] - 11'h123) < 11'h10), 32'h1);
    bus(1'b1, 7'h38, 32'hFFFF_0002);
    bus(1'b0, 7'h38, '0);
    chk("rx pause written", 32'(rd < 32'h3), 32'h1);
    for (n = 0; n < 800 && pause_send_req_o !== 1'b1; n++) @(posedge clk_sys_i);
    tmo(n, 800);
    @(posedge clk_sys_i);
    chk("pause request pulse", 32'(pause_send_req_o), 32'h0);
    bus(1'b0, 7'h38, '0);
    chk("rx pause reload", 32'((16'hFF00 - rd[15:0]) < 16'h2), 32'h1);
    tmode(1'b0);
    bus(1'b1, 7'h38, 32'h0000_0005);
    bus(1'b0, 7'h38, '0);
    chk("rx pause guarded", 32'((16'hFF00 - rd[15:0]) < 16'h3), 32'h1);
    ev_go('{pause_rx: 1'b1, pause_rx_time: 16'h0003, default: '0});
    chk("hold set", 32'(tx_hold_o), 32'h1);
    for (n = 0; n < 1000 && tx_hold_o !== 1'b0; n++) @(posedge clk_sys_i);
    tmo(n, 1000);
    chk("hold span", 32'(n >= 510 && n <= 770), 32'h1);
    $display("test pause done");
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    bus(1'b0, 7'h30, '0);
    chk("generator after reset", 32'(rd[26:16] < 11'h8), 32'h1);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ROWS[i][70:64], '0);
      chk("reset value", rd, 32'h0);
    end
    chk("enables after reset", 32'(chan_match_en_o), 32'h0);
    $display("test reset done");
    stop_test();
  end
endmodule // mafpb_top_tb
